// ### rtl/adc_dev_end.sv
// Converter end of the serial link: framing, control/shadow loading,
// track-and-hold timing and power modes.
// Assumes the link pins are asynchronous to MCLK; the serial clock is
// found by sampling, so it must stay well below MCLK / 6.
`default_nettype none
module adc_dev_end
	import adc_link_pkg::*;
(
	// System
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// Link
	adc_link_if.dev          link,
	// Analog front end
	input  wire logic [11:0] SAMPLE_DATA,
	output var  logic [2:0]  SAMPLE_CHAN,
	output var  logic        TRACK,
	// State seen by the user side
	output var  logic [1:0]  POWER_STATE,
	output var  logic [11:0] CTRL_WORD,
	output var  logic [15:0] SHADOW_WORD
);
	typedef struct packed {
		logic        active;
		logic [4:0]  cnt;
		logic [15:0] word_out;
		logic [15:0] word_in;
		logic        dout;
		logic        dout_oe;
		logic        track;
		pwr_t        pwr;
		logic [11:0] ctrl;
		logic [15:0] shadow;
		logic        shadow_next;
		logic        shadow_frame;
		logic [2:0]  chan;
	} dev_t;

	dev_t r;
	dev_t next_r;

	logic cs_level;
	logic cs_rise;
	logic cs_fall;
	logic sclk_fall;
	logic din_level;

	pin_sync3 cs_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.d     (link.cs_n),
		.level (cs_level),
		.rise  (cs_rise),
		.fall  (cs_fall)
	);

	pin_sync3 sclk_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.d     (link.sclk),
		.level (),
		.rise  (),
		.fall  (sclk_fall)
	);

	pin_sync3 din_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.d     (link.din),
		.level (din_level),
		.rise  (),
		.fall  ()
	);

	always_comb begin
		logic [4:0]  k;
		logic [11:0] cw;
		k = r.cnt + 5'h01;
		cw = r.word_in[15:4];
		next_r = r;
		// While down and idle the sampler stays in hold
		if (r.pwr != PWR_ON && !r.active) begin
			next_r.track = 1'b0;
		end
		if (cs_fall) begin
			next_r.active = 1'b1;
			next_r.cnt = 5'h00;
			next_r.word_in = 16'h0000;
			next_r.shadow_frame = r.shadow_next;
			next_r.word_out = {1'b0, r.chan, SAMPLE_DATA};
			next_r.dout = 1'b0;
			// A full-shutdown wake transfer leaves the output undriven
			next_r.dout_oe = (r.pwr != PWR_FULL_DOWN);
			if (r.pwr == PWR_AUTO_DOWN) begin
				next_r.pwr = PWR_ON;
				next_r.track = 1'b1;
			end else begin
				next_r.track = 1'b0;
			end
		end else if (r.active && sclk_fall && r.cnt < FRAME_BITS) begin
			next_r.cnt = k;
			next_r.word_in = {r.word_in[14:0], din_level};
			next_r.word_out = {r.word_out[14:0], 1'b0};
			next_r.dout = r.word_out[14];
			if (k == TRACK_EDGE && !r.shadow_frame) begin
				next_r.track = 1'b1;
			end
			if (k == FRAME_BITS) begin
				next_r.dout_oe = 1'b0;
			end
		end else if (r.active && cs_rise) begin
			next_r.active = 1'b0;
			next_r.dout_oe = 1'b0;
			if (r.cnt != FRAME_BITS) begin
				// Aborted frame: nothing is committed
				if (r.pwr == PWR_ON) begin
					next_r.track = 1'b1;
				end
			end else if (r.shadow_frame) begin
				next_r.shadow = r.word_in;
				next_r.shadow_next = 1'b0;
				next_r.chan = first_chan(r.word_in[15:8]);
				next_r.track = 1'b1;
			end else if (cw[CTRL_WRITE]) begin
				next_r.ctrl = cw;
				next_r.shadow_next = wants_shadow(cw);
				next_r.chan = cw[CTRL_CHAN_HI:CTRL_CHAN_LO];
				case (cw[CTRL_PM_HI:CTRL_PM_LO])
					PM_AUTO: begin
						next_r.pwr = PWR_AUTO_DOWN;
						next_r.track = 1'b0;
					end
					PM_FULL: begin
						next_r.pwr = PWR_FULL_DOWN;
						next_r.track = 1'b0;
					end
					PM_NORMAL: begin
						// Powers up from full shutdown at this edge
						next_r.pwr = PWR_ON;
					end
					default: begin
						next_r.pwr = r.pwr;
					end
				endcase
			end
		end else if (!cs_level && !r.active) begin
			// Select low before the filter saw a fall cannot occur;
			// kept idle so the state stays defined
			next_r.active = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			r <= '{
				active: 1'b0, cnt: 5'h00, word_out: 16'h0000,
				word_in: 16'h0000, dout: 1'b0, dout_oe: 1'b0,
				track: 1'b1, pwr: PWR_ON, ctrl: CTRL_RESET,
				shadow: SHADOW_RESET, shadow_next: 1'b0,
				shadow_frame: 1'b0, chan: 3'h0
			};
		end else begin
			r <= next_r;
		end
	end

	assign link.dout    = r.dout;
	assign link.dout_oe = r.dout_oe;
	assign SAMPLE_CHAN  = r.chan;
	assign TRACK        = r.track;
	assign POWER_STATE  = r.pwr;
	assign CTRL_WORD    = r.ctrl;
	assign SHADOW_WORD  = r.shadow;
endmodule
`default_nettype wire

// ### rtl/adc_host_end.sv
// Controller end of the serial link with an AXI4-Lite register slave.
// Assumes software issues one transfer at a time through the command
// register and polls the status register for completion.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`default_nettype none
module adc_host_end
	import adc_link_pkg::*;
(
	// System
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// AXI4-Lite write
	input  wire logic [3:0]  AWADDR,
	input  wire logic        AWVALID,
	output var  logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output var  logic        WREADY,
	output var  logic [1:0]  BRESP,
	output var  logic        BVALID,
	input  wire logic        BREADY,
	// AXI4-Lite read
	input  wire logic [3:0]  ARADDR,
	input  wire logic        ARVALID,
	output var  logic        ARREADY,
	output var  logic [31:0] RDATA,
	output var  logic [1:0]  RRESP,
	output var  logic        RVALID,
	input  wire logic        RREADY,
	// Link
	adc_link_if.host         link
);
	typedef struct packed {
		host_state_t st;
		logic [15:0] tmr;
		logic [4:0]  bitn;
		logic [15:0] tx;
		logic [15:0] sh;
		logic [15:0] rx;
		logic        sclk;
		logic        cs_n;
		logic        din;
		logic        busy;
		logic        done;
		logic        refused;
		logic [1:0]  init_left;
		logic [1:0]  frames;
		logic        shadow_next;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} host_t;

	host_t r;
	host_t next_r;
	logic  dout_level;

	pin_sync3 dout_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.d     (link.dout_line),
		.level (dout_level),
		.rise  (),
		.fall  ()
	);

	always_comb begin
		logic [15:0] w;
		logic        wr_go;
		w = WDATA[15:0];
		wr_go = r.wready && AWVALID && WVALID;
		next_r = r;
		if (r.tmr != 16'h0000) begin
			next_r.tmr = r.tmr - 16'h0001;
		end
		// Write channel: address and data are taken together
		next_r.wready = AWVALID && WVALID && !r.wready && !r.bvalid;
		if (r.bvalid && BREADY) begin
			next_r.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_r.bvalid = 1'b1;
			next_r.bresp = (AWADDR == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
		end
		if (wr_go && AWADDR == REG_CMD && !r.busy) begin
			next_r.done = 1'b0;
			next_r.refused = 1'b0;
			if (r.shadow_next && r.frames != 2'h3) begin
				next_r.refused = 1'b1;
			end else begin
				if (r.shadow_next && WDATA[CMD_SINGLE]) begin
					w[7:0] = 8'h00;
				end
				next_r.tx = w;
				next_r.busy = 1'b1;
				next_r.init_left = 2'h0;
				if (WDATA[CMD_INIT]) begin
					// Second high dummy only needed for auto shutdown
					next_r.init_left =
						(w[15:12] != 4'hf &&
						 w[CTRL_PM_HI + 4:CTRL_PM_LO + 4] == PM_AUTO) ?
						2'h2 : 2'h1;
				end
				next_r.st = H_WAIT;
				next_r.tmr = WDATA[CMD_WAKE_WAIT] ?
					16'(WAKE_CYC) : 16'h0000;
			end
		end else if (wr_go && AWADDR == REG_CMD) begin
			next_r.refused = 1'b1;
		end
		// Read channel
		next_r.arready = ARVALID && !r.arready && !r.rvalid;
		if (r.rvalid && RREADY) begin
			next_r.rvalid = 1'b0;
		end
		if (r.arready && ARVALID) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			case (ARADDR)
				REG_CMD: next_r.rdata = {16'h0000, r.tx};
				REG_STATUS: next_r.rdata = {26'h0, r.frames,
					r.shadow_next, r.refused, r.done, r.busy};
				REG_RX: next_r.rdata = {16'h0000, r.rx};
				default: begin
					next_r.rdata = 32'h0000_0000;
					next_r.rresp = RESP_SLVERR;
				end
			endcase
		end
		// Link sequencer: serial clock is a divided MCLK
		case (r.st)
			H_IDLE: begin
				next_r.cs_n = 1'b1;
			end
			H_WAIT: begin
				if (r.tmr == 16'h0000) begin
					// Dummy frames carry all ones on the serial input
					next_r.sh = (r.init_left != 2'h0) ? 16'hffff : r.tx;
					next_r.din = (r.init_left != 2'h0) ? 1'b1 : r.tx[15];
					next_r.cs_n = 1'b0;
					next_r.bitn = 5'h00;
					next_r.st = H_HIGH;
					next_r.tmr = 16'(SCLK_HALF_CYC);
				end
			end
			H_HIGH: begin
				if (r.tmr == 16'h0000) begin
					if (r.bitn == FRAME_BITS) begin
						next_r.cs_n = 1'b1;
						next_r.st = H_QUIET;
						next_r.tmr = 16'(QUIET_CYC);
					end else begin
						next_r.sclk = 1'b0;
						next_r.rx = {r.rx[14:0], dout_level};
						next_r.bitn = r.bitn + 5'h01;
						next_r.st = H_LOW;
						next_r.tmr = 16'(SCLK_HALF_CYC);
					end
				end
			end
			H_LOW: begin
				if (r.tmr == 16'h0000) begin
					next_r.sclk = 1'b1;
					next_r.sh = {r.sh[14:0], 1'b0};
					next_r.din = r.sh[14];
					next_r.st = H_HIGH;
					next_r.tmr = 16'(SCLK_HALF_CYC);
				end
			end
			H_QUIET: begin
				if (r.tmr == 16'h0000) begin
					if (r.frames != 2'h3) begin
						next_r.frames = r.frames + 2'h1;
					end
					if (r.init_left != 2'h0) begin
						next_r.init_left = r.init_left - 2'h1;
						next_r.st = H_WAIT;
					end else begin
						if (r.shadow_next) begin
							next_r.shadow_next = 1'b0;
						end else if (r.tx[15]) begin
							next_r.shadow_next = wants_shadow(r.tx[15:4]);
						end
						next_r.busy = 1'b0;
						next_r.done = 1'b1;
						next_r.st = H_IDLE;
					end
				end
			end
			default: begin
				next_r.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			r <= '{
				st: H_IDLE, tmr: 16'h0000, bitn: 5'h00,
				tx: 16'h0000, sh: 16'h0000, rx: 16'h0000,
				sclk: 1'b1, cs_n: 1'b1, din: 1'b0, busy: 1'b0,
				done: 1'b0, refused: 1'b0, init_left: 2'h0,
				frames: 2'h0, shadow_next: 1'b0, wready: 1'b0,
				bvalid: 1'b0, bresp: 2'h0, arready: 1'b0,
				rvalid: 1'b0, rresp: 2'h0, rdata: 32'h0000_0000
			};
		end else begin
			r <= next_r;
		end
	end

	assign AWREADY   = r.wready;
	assign WREADY    = r.wready;
	assign BVALID    = r.bvalid;
	assign BRESP     = r.bresp;
	assign ARREADY   = r.arready;
	assign RVALID    = r.rvalid;
	assign RRESP     = r.rresp;
	assign RDATA     = r.rdata;
	assign link.cs_n = r.cs_n;
	assign link.sclk = r.sclk;
	assign link.din  = r.din;
endmodule
`default_nettype wire

// ### rtl/adc_link_if.sv
// Serial link between the converter end and the controller end.
// The output line is modelled with a pull-up when nobody drives it.
`default_nettype none
interface adc_link_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe;
	logic dout_line;

	assign dout_line = dout_oe ? dout : 1'b1;

	modport dev (
		input  cs_n,
		input  sclk,
		input  din,
		output dout,
		output dout_oe
	);
	modport host (
		output cs_n,
		output sclk,
		output din,
		input  dout_line
	);
endinterface
`default_nettype wire

// ### rtl/adc_link_pkg.sv
// Shared constants and types for the converter serial link.
// Assumes a 200 MHz system clock on both ends of the link.
`default_nettype none
package adc_link_pkg;
	localparam int CLK_NS        = 5;
	localparam int SCLK_PERIOD_NS = 125;
	localparam int SCLK_HALF_CYC =
		(SCLK_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	localparam int WAKE_NS       = 1000;
	localparam int WAKE_CYC      = (WAKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int QUIET_NS      = 50;
	localparam int QUIET_CYC     = (QUIET_NS + CLK_NS - 1) / CLK_NS;

	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] TRACK_EDGE = 5'h0e;

	// Control word bit positions within the 12 captured bits
	localparam int CTRL_WRITE  = 11;
	localparam int CTRL_SEQ    = 10;
	localparam int CTRL_CHAN_HI = 8;
	localparam int CTRL_CHAN_LO = 6;
	localparam int CTRL_PM_HI  = 5;
	localparam int CTRL_PM_LO  = 4;
	localparam int CTRL_SHADOW = 3;

	localparam logic [1:0] PM_NORMAL = 2'h3;
	localparam logic [1:0] PM_FULL   = 2'h2;
	localparam logic [1:0] PM_AUTO   = 2'h1;

	localparam logic [11:0] CTRL_RESET   = 12'h030;
	localparam logic [15:0] SHADOW_RESET = 16'h0000;

	// Controller register map
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_RX     = 4'h8;
	localparam int CMD_INIT      = 16;
	localparam int CMD_WAKE_WAIT = 17;
	localparam int CMD_SINGLE    = 18;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PWR_ON        = 2'h0,
		PWR_AUTO_DOWN = 2'h1,
		PWR_FULL_DOWN = 2'h3
	} pwr_t;

	typedef enum logic [2:0] {
		H_IDLE  = 3'h0,
		H_WAIT  = 3'h1,
		H_HIGH  = 3'h3,
		H_LOW   = 3'h2,
		H_QUIET = 3'h6
	} host_state_t;

	// Lowest channel enabled in a sequence selection byte
	function automatic logic [2:0] first_chan(input logic [7:0] sel);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (sel[i]) begin
				c = 3'(i);
			end
		end
		return c;
	endfunction

	// Shadow programming is selected by sequence off, shadow on
	function automatic logic wants_shadow(input logic [11:0] ctrl);
		return ctrl[CTRL_WRITE] && !ctrl[CTRL_SEQ] && ctrl[CTRL_SHADOW];
	endfunction
endpackage
`default_nettype wire

// ### rtl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the input is asynchronous to clk.
`default_nettype none
module pin_sync3 (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin
	input  wire logic d,
	// Filtered level and edges
	output var  logic level,
	output var  logic rise,
	output var  logic fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_t;

	sync_t r;
	sync_t next_r;

	always_comb begin
		next_r = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.s2 == r.s3) begin
			next_r.lvl = r.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	// Edge seen when the agreeing stages differ from the held level
	assign level = r.lvl;
	assign rise  = (r.s2 == r.s3) && r.s3 && !r.lvl;
	assign fall  = (r.s2 == r.s3) && !r.s3 && r.lvl;
endmodule
`default_nettype wire

// ### testbench/adc_link_checker.sv
// Wire checks on the link joining the two design ends.
// Assumes the signals of that one interface and the system clock.
`default_nettype none
module adc_link_checker import adc_link_pkg::*; (
	// System
	input wire logic MCLK,
	input wire logic RST_N,
	// Link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sclk_q;
	logic [4:0] falls;

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// Serial clock falls seen in the current frame
	always_ff @(posedge MCLK) begin
		sclk_q <= sclk;
		if (!RST_N || cs_n)
			falls <= 5'h0;
		else if (sclk_q && !sclk)
			falls <= falls + 5'h1;
	end

	a_frame_sixteen: assert property (
		$rose(cs_n) |-> falls == FRAME_BITS)
		else $error("frame ended without sixteen falls");
	a_oe_held: assert property (
		dout_oe && !cs_n && falls < 5'hf |=> dout_oe)
		else $error("output released inside frame");
	a_oe_at_select: assert property (
		$rose(dout_oe) |-> !cs_n && falls == 5'h0)
		else $error("output driven outside frame start");
	a_lead_zero: assert property (
		$rose(dout_oe) |-> !dout)
		else $error("first bit not zero");
	a_bit_on_fall: assert property (
		dout_oe && $past(dout_oe) && $changed(dout)
		|-> !sclk && falls != 5'h0)
		else $error("output bit moved off a fall");
	a_release_16: assert property (
		falls == FRAME_BITS |-> ##[0:8] !dout_oe)
		else $error("output not released after last fall");
	a_release_rise: assert property (
		$rose(cs_n) |-> ##[1:8] !dout_oe)
		else $error("output not released at select rise");
	a_din_on_rise: assert property (
		$changed(din) |-> sclk)
		else $error("input bit moved while clock low");
endmodule
`default_nettype wire

// ### testbench/adc_serial_power_control_bench.sv
// Bench for both link ends, plus a second converter end driven by hand.
// Assumes the package, the link interface and both end modules.
`default_nettype none
module adc_serial_power_control_bench import adc_link_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        MCLK = 1'b0, RST_N = 1'b0;
	logic [3:0]  AWADDR = 4'h0, ARADDR = 4'h0;
	logic        AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
	logic        BREADY = 1'b1, RREADY = 1'b1;
	logic [31:0] WDATA = 32'h0, RDATA, rdat;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0]  BRESP, RRESP, POWER_STATE, resp, ps_end;
	logic [11:0] SAMPLE_DATA = 12'h5a3, CTRL_WORD, ctrl2;
	logic [2:0]  SAMPLE_CHAN;
	logic [15:0] SHADOW_WORD, rx_bits, tx_bits;
	logic        TRACK, oe_seen, trk_end, sclk_q, cs_q;
	int          miscompares = 0, n_checks = 0, cyc = 0;
	int          t_rise = 0, gap = 0;

	adc_link_if lk ();
	adc_link_if lk2 ();
	adc_dev_end u_adc_dev_end (.MCLK(MCLK), .RST_N(RST_N), .link(lk.dev),
		.SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_CHAN(SAMPLE_CHAN),
		.TRACK(TRACK), .POWER_STATE(POWER_STATE), .CTRL_WORD(CTRL_WORD),
		.SHADOW_WORD(SHADOW_WORD));
	adc_dev_end u_adc_dev_end_2 (.MCLK(MCLK), .RST_N(RST_N),
		.link(lk2.dev), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_CHAN(),
		.TRACK(), .POWER_STATE(), .CTRL_WORD(ctrl2), .SHADOW_WORD());
	adc_host_end u_adc_host_end (.MCLK(MCLK), .RST_N(RST_N),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.link(lk.host));
	adc_link_checker u_adc_link_checker (.MCLK(MCLK), .RST_N(RST_N),
		.cs_n(lk.cs_n), .sclk(lk.sclk), .din(lk.din), .dout(lk.dout),
		.dout_oe(lk.dout_oe));

	initial begin
		forever #2.5 MCLK = ~MCLK;
	end

	// The host samples the line at each fall it makes, so does the bench
	always @(posedge MCLK) begin
		sclk_q <= lk.sclk;
		cs_q <= lk.cs_n;
		cyc <= cyc + 1;
		if (cs_q && !lk.cs_n) begin
			oe_seen <= 1'b0;
			gap <= cyc - t_rise;
		end else if (lk.dout_oe)
			oe_seen <= 1'b1;
		if (!lk.cs_n && sclk_q && !lk.sclk) begin
			rx_bits <= {rx_bits[14:0], lk.dout_line};
			tx_bits <= {tx_bits[14:0], lk.din};
		end
		if (!cs_q && lk.cs_n) begin
			t_rise <= cyc;
			ps_end <= POWER_STATE;
			trk_end <= TRACK;
		end
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do begin
			@(posedge MCLK);
			if (AWVALID && AWREADY)
				AWVALID <= 1'b0;
			if (WVALID && WREADY)
				WVALID <= 1'b0;
		end while (!((!AWVALID || AWREADY) && (!WVALID || WREADY)));
		do @(posedge MCLK); while (!BVALID);
		resp = BRESP;
	endtask

	task automatic rd(input logic [3:0] a);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge MCLK); while (!ARREADY);
		ARVALID <= 1'b0;
		do @(posedge MCLK); while (!RVALID);
		rdat = RDATA;
		resp = RRESP;
	endtask

	// One command, then poll until the frame is done
	task automatic send(input logic [31:0] cmd);
		wr(REG_CMD, cmd);
		check("cmd resp", 32'(resp), 32'(RESP_OKAY));
		do rd(REG_STATUS); while (rdat[1] !== 1'b1);
	endtask

	task automatic t_reset;
		check("ctrl reset", 32'(CTRL_WORD), 32'(CTRL_RESET));
		check("power reset", 32'(POWER_STATE), 32'(PWR_ON));
		rd(4'hc);
		check("rd unmapped", 32'(resp), 32'(RESP_SLVERR));
		wr(4'hc, 32'h0);
		check("wr unmapped", 32'(resp), 32'(RESP_SLVERR));
		$display("test reset done");
	endtask

	// Control words: channel 5, power mode in bits 9:8 of the word
	task automatic t_init;
		send(32'hb700 | (32'h1 << CMD_INIT));
		check("ctrl init", 32'(CTRL_WORD), 32'hb70);
		check("din word", 32'(tx_bits), 32'hb700);
		check("power init", 32'(POWER_STATE), 32'(PWR_ON));
		SAMPLE_DATA <= 12'hc3a;
		send(32'h0);
		check("ctrl kept", 32'(CTRL_WORD), 32'hb70);
		check("track 14", 32'(trk_end), 32'h1);
		check("line word", 32'(rx_bits), 32'h5c3a);
		rd(REG_RX);
		check("rx word", 32'(rdat[15:0]), 32'h5c3a);
		$display("test init done");
	endtask

	task automatic t_shadow;
		send(32'haf80);
		rd(REG_STATUS);
		check("pending", 32'(rdat[5:2]), 32'he);
		send(32'h24ff | (32'h1 << CMD_SINGLE));
		check("shadow", 32'(SHADOW_WORD), 32'h2400);
		check("ctrl shadow", 32'(CTRL_WORD), 32'haf8);
		check("hold shadow", 32'(trk_end), 32'h0);
		check("first chan", 32'(SAMPLE_CHAN), 32'h2);
		check("track commit", 32'(TRACK), 32'h1);
		$display("test shadow done");
	endtask

	task automatic t_auto;
		send(32'hb500);
		check("auto down", 32'(POWER_STATE),
			32'(PWR_AUTO_DOWN));
		check("auto hold", 32'(TRACK), 32'h0);
		send(32'h0);
		check("ctrl dummy", 32'(CTRL_WORD), 32'hb50);
		check("awake", 32'(ps_end), 32'(PWR_ON));
		send(32'hb700 | (32'h1 << CMD_WAKE_WAIT));
		check("wake gap", 32'(gap >= WAKE_CYC), 32'h1);
		check("ctrl normal", 32'(CTRL_WORD), 32'hb70);
		$display("test auto done");
	endtask

	task automatic t_full;
		send(32'hb600);
		send(32'h0);
		check("full down", 32'(POWER_STATE),
			32'(PWR_FULL_DOWN));
		check("full hold", 32'(TRACK), 32'h0);
		send(32'hb700);
		check("wake quiet", 32'(oe_seen), 32'h0);
		repeat (6) @(posedge MCLK);
		check("full up", 32'(POWER_STATE), 32'(PWR_ON));
		$display("test full done");
	endtask

	// Select rises after five clocks with every input bit high
	task automatic t_abort;
		lk2.cs_n <= 1'b0;
		lk2.din <= 1'b1;
		repeat (13) @(posedge MCLK);
		repeat (5) begin
			lk2.sclk <= 1'b0;
			repeat (12) @(posedge MCLK);
			lk2.sclk <= 1'b1;
			repeat (13) @(posedge MCLK);
		end
		check("oe mid", 32'(lk2.dout_oe), 32'h1);
		lk2.cs_n <= 1'b1;
		repeat (8) @(posedge MCLK);
		check("oe abort", 32'(lk2.dout_oe), 32'h0);
		check("ctrl abort", 32'(ctrl2), 32'(CTRL_RESET));
		$display("test abort done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		lk2.cs_n = 1'b1;
		lk2.sclk = 1'b1;
		lk2.din = 1'b0;
		repeat (6) @(posedge MCLK);
		RST_N <= 1'b1;
		repeat (4) @(posedge MCLK);
		t_reset();
		t_init();
		t_shadow();
		t_auto();
		t_full();
		t_abort();
		report_and_stop();
	end
endmodule
`default_nettype wire
